//--- fbsr_pkg.sv
package fbsr_pkg;

   localparam int unsigned FBSR_STAGES     = 4;
   localparam int unsigned FBSR_FIFO_DEPTH = 32;
   localparam int unsigned FBSR_FIFO_AW    = 5;

   localparam logic [3:0] FBSR_STAGE_RST = 4'h0;
   localparam logic       FBSR_INV_RST   = 1'b1;
   localparam logic       FBSR_CLK_RST   = 1'b0;

   typedef enum logic [1:0] {
      FBSR_MODE_HOLD,
      FBSR_MODE_LOAD,
      FBSR_MODE_SHIFT
   } fbsr_mode_e;

   // Mode select: shift enable wins over parallel load enable
   function automatic fbsr_mode_e fbsr_mode(input logic shift_en, input logic load_en);
      if (shift_en) begin
         return FBSR_MODE_SHIFT;
      end else if (load_en) begin
         return FBSR_MODE_LOAD;
      end
      return FBSR_MODE_HOLD;
   endfunction

   // Next stage word for one clock event
   function automatic logic [3:0] fbsr_next(input fbsr_mode_e mode,
                                            input logic [3:0] cur,
                                            input logic       ser,
                                            input logic [3:0] par);
      case (mode)
         FBSR_MODE_SHIFT: return {cur[2:0], ser};
         FBSR_MODE_LOAD:  return par;
         FBSR_MODE_HOLD:  return cur;
         default:         return cur;
      endcase
   endfunction

endpackage

//--- fbsr_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module fbsr_fifo #(
   parameter int unsigned WIDTH = 4,
   parameter int unsigned DEPTH = 32,
   parameter int unsigned AW    = 5
) (
   input  wire logic             clock_i,
   input  wire logic             reset_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;
   logic             head_valid_q;
   logic [WIDTH-1:0] head_q;

   wire logic push;
   wire logic pop;
   wire logic head_free;

   assign head_free   = !head_valid_q || out_ready_i;
   assign in_ready_o  = count_q != (AW + 1)'(DEPTH);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = (count_q != '0) && head_free;
   assign out_valid_o = head_valid_q;
   assign out_data_o  = head_q;

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= AW'((wr_ptr_q + 1'b1) % DEPTH);
         end
         if (pop) begin
            rd_ptr_q <= AW'((rd_ptr_q + 1'b1) % DEPTH);
         end
         count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         head_valid_q <= 1'b0;
         head_q       <= '0;
      end else if (pop) begin
         head_valid_q <= 1'b1;
         head_q       <= mem_q[rd_ptr_q];
      end else if (out_ready_i) begin
         head_valid_q <= 1'b0;
      end
   end

endmodule

`default_nettype wire

//--- fbsr_top.sv
// Contract
// - Four storage stages, each driven on its own parallel output.
// - Stages change only on falling edge of the stage clock, except clearing.
// - Low master clear forces stages low at once, inverted output high.
// - Shift enable high: serial input to stage zero, stages move right.
// - Shift enable low: load parallel inputs if load enable high, else hold.
// - Extra output is always the inverse of stage three.
`timescale 1ns/1ns
`default_nettype none

module fbsr_top
   import fbsr_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       reset_n_i,
   input  wire logic       falling_edge_clock_i,
   input  wire logic       master_clear_n_i,
   input  wire logic       shift_enable_i,
   input  wire logic       parallel_load_enable_i,
   input  wire logic       serial_in_i,
   input  wire logic [3:0] parallel_in_i,
   output logic      [3:0] stage_out_o,
   output logic            last_stage_inverted_o,
   output logic            stream_valid_o,
   input  wire logic       stream_ready_i,
   output logic      [3:0] stream_data_o
);

   logic       clk_prev_q;
   logic       pend_q;
   logic       pend_d;
   fbsr_mode_e mode_q;
   logic       ser_q;
   logic [3:0] par_q;
   logic [3:0] stage_q;
   logic [3:0] stage_d;
   logic       inv_q;
   logic       fifo_valid_q;
   logic [3:0] fifo_data_q;
   logic       out_valid_q;
   logic [3:0] out_data_q;

   wire logic       clear_n;
   wire logic       fall;
   wire logic       fifo_ready;
   wire logic       apply;
   wire logic       fifo_out_valid;
   wire logic [3:0] fifo_out_data;
   wire logic       out_take;

   // Combined asynchronous clear
   assign clear_n  = reset_n_i && master_clear_n_i;
   // High-to-low transition of the stage clock
   assign fall     = clk_prev_q && !falling_edge_clock_i;
   // A captured event is applied once the stream can accept its word
   assign apply    = pend_q && !fifo_valid_q;
   assign stage_d  = fbsr_next(mode_q, stage_q, ser_q, par_q);
   assign pend_d   = fall || (pend_q && !apply);
   assign out_take = !out_valid_q || stream_ready_i;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         clk_prev_q <= FBSR_CLK_RST;
      end else begin
         clk_prev_q <= falling_edge_clock_i;
      end
   end

   // Controls sampled only at the falling edge
   always_ff @(posedge clock_i or negedge clear_n) begin
      if (!clear_n) begin
         pend_q <= 1'b0;
         mode_q <= FBSR_MODE_HOLD;
         ser_q  <= 1'b0;
         par_q  <= FBSR_STAGE_RST;
      end else begin
         pend_q <= pend_d;
         if (fall) begin
            mode_q <= fbsr_mode(shift_enable_i, parallel_load_enable_i);
            ser_q  <= serial_in_i;
            par_q  <= parallel_in_i;
         end
      end
   end

   // Four stages and the inverted last stage
   always_ff @(posedge clock_i or negedge clear_n) begin
      if (!clear_n) begin
         stage_q <= FBSR_STAGE_RST;
         inv_q   <= FBSR_INV_RST;
      end else if (apply) begin
         stage_q <= stage_d;
         inv_q   <= !stage_d[3];
      end
   end

   // Word handed to the FIFO; a full FIFO stalls further events
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fifo_valid_q <= 1'b0;
         fifo_data_q  <= FBSR_STAGE_RST;
      end else if (apply) begin
         fifo_valid_q <= 1'b1;
         fifo_data_q  <= stage_d;
      end else if (fifo_ready) begin
         fifo_valid_q <= 1'b0;
      end
   end

   fbsr_fifo #(
      .WIDTH (FBSR_STAGES),
      .DEPTH (FBSR_FIFO_DEPTH),
      .AW    (FBSR_FIFO_AW)
   ) u_fifo (
      .clock_i     (clock_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (fifo_valid_q),
      .in_ready_o  (fifo_ready),
      .in_data_i   (fifo_data_q),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (out_take),
      .out_data_o  (fifo_out_data)
   );

   // Registered stream output stage
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         out_valid_q <= 1'b0;
         out_data_q  <= FBSR_STAGE_RST;
      end else if (out_take) begin
         out_valid_q <= fifo_out_valid;
         out_data_q  <= fifo_out_data;
      end
   end

   assign stage_out_o           = stage_q;
   assign last_stage_inverted_o = inv_q;
   assign stream_valid_o        = out_valid_q;
   assign stream_data_o         = out_data_q;

endmodule

`default_nettype wire

//--- fbsr_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module fbsr_top_monitor (
   input wire logic       clock_i,
   input wire logic       reset_n_i,
   input wire logic       falling_edge_clock_i,
   input wire logic       master_clear_n_i,
   input wire logic       shift_enable_i,
   input wire logic       parallel_load_enable_i,
   input wire logic       serial_in_i,
   input wire logic [3:0] parallel_in_i,
   input wire logic [3:0] stage_out_o,
   input wire logic       last_stage_inverted_o,
   input wire logic       stream_valid_o,
   input wire logic       stream_ready_i,
   input wire logic [3:0] stream_data_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   // Stage clock high-to-low step with clear inactive
   sequence s_event;
      falling_edge_clock_i ##1 !falling_edge_clock_i && master_clear_n_i;
   endsequence
   // Stages update one edge after the event and are seen one edge later still
   AST_SHIFT: assert property (s_event ##0 shift_enable_i |-> ##2 (!master_clear_n_i
      || stage_out_o == {$past(stage_out_o[2:0], 2), $past(serial_in_i, 2)}))
      else $error("shift result wrong");
   AST_LOAD: assert property (s_event ##0 !shift_enable_i && parallel_load_enable_i
      |-> ##2 (!master_clear_n_i || stage_out_o == $past(parallel_in_i, 2)))
      else $error("load result wrong");
   AST_HOLD: assert property (s_event ##0 !(shift_enable_i || parallel_load_enable_i)
      |-> ##2 (!master_clear_n_i || stage_out_o == $past(stage_out_o, 2)))
      else $error("hold changed stages");
   AST_EDGE: assert property ($changed(stage_out_o) && master_clear_n_i
      && $past(master_clear_n_i) |-> $past(falling_edge_clock_i, 3)
      && !$past(falling_edge_clock_i, 2))
      else $error("stages changed without falling edge");
   AST_CLEAR: assert property (!master_clear_n_i |-> stage_out_o == 4'h0
      && last_stage_inverted_o)
      else $error("clear not applied");
   AST_INV: assert property (last_stage_inverted_o == !stage_out_o[3])
      else $error("inverted output wrong");
   AST_STAND: assert property (stream_valid_o && !stream_ready_i
      |=> stream_valid_o && $stable(stream_data_o))
      else $error("stream word dropped");
endmodule
bind fbsr_top fbsr_top_monitor mon (.clock_i(clock_i), .reset_n_i(reset_n_i),
   .falling_edge_clock_i(falling_edge_clock_i), .master_clear_n_i(master_clear_n_i),
   .shift_enable_i(shift_enable_i), .parallel_load_enable_i(parallel_load_enable_i),
   .serial_in_i(serial_in_i), .parallel_in_i(parallel_in_i), .stage_out_o(stage_out_o),
   .last_stage_inverted_o(last_stage_inverted_o), .stream_valid_o(stream_valid_o),
   .stream_ready_i(stream_ready_i), .stream_data_o(stream_data_o));
`default_nettype wire

//--- fbsr_sink.sv
`timescale 1ns/1ns
`default_nettype none
// Stream consumer, ready always or one cycle in four, never while stalled
module fbsr_sink (
   input  wire logic clock_i,
   input  wire logic reset_n_i,
   input  wire logic stall_i,
   input  wire logic slow_i,
   output logic      ready_o
);
   logic [1:0] cnt_q;
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q   <= 2'h0;
         ready_o <= 1'b0;
      end else begin
         cnt_q   <= cnt_q + 2'h1;
         ready_o <= !stall_i && (!slow_i || cnt_q == 2'h0);
      end
   end
endmodule
`default_nettype wire

//--- fbsr_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module fbsr_top_bench;
   logic       clk = 0, rn = 0, fc = 0, cn = 1, se = 0, pe = 0, si = 0, stall = 0, slow = 0;
   logic [3:0] par = 4'h0, ex = 4'h0, st, sd;
   logic       inv, sv, rdy;
   logic [3:0] notes[$];
   int         err_total = 0, comparisons = 0, seed = 32'hA9E76D14, i;
   initial forever #5 clk = ~clk;
   fbsr_top dut (.clock_i(clk), .reset_n_i(rn), .falling_edge_clock_i(fc),
      .master_clear_n_i(cn), .shift_enable_i(se), .parallel_load_enable_i(pe),
      .serial_in_i(si), .parallel_in_i(par), .stage_out_o(st), .last_stage_inverted_o(inv),
      .stream_valid_o(sv), .stream_ready_i(rdy), .stream_data_o(sd));
   fbsr_sink sink (.clock_i(clk), .reset_n_i(rn), .stall_i(stall), .slow_i(slow),
      .ready_o(rdy));
   task automatic cmp(input string what, input logic [3:0] e, input logic [3:0] s);
      comparisons++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // One stage clock event; junk inputs while high, real ones at the fall
   task automatic step(input logic s, input logic p);
      @(negedge clk);
      {se, pe, si, par} = 7'($random(seed));
      fc = 1'b1;
      @(negedge clk);
      cmp("stage word at rise", ex, st);
      {se, pe, si, par} = {s, p, 5'($random(seed))};
      fc = 1'b0;
      ex = s ? {ex[2:0], si} : (p ? par : ex);
      notes.push_back(ex);
      repeat (2) @(negedge clk);
      cmp("stage word", ex, st);
      cmp("inverted stage", {3'h0, ~ex[3]}, {3'h0, inv});
   endtask
   task automatic drain();
      int j;
      for (j = 0; j < 300 && notes.size() > 0; j++) @(negedge clk);
      if (notes.size() > 0) begin
         err_total++;
         $display("unexpected backlog expected 0 seen %0d", notes.size());
         test_done();
      end
   endtask
   always @(negedge clk) begin
      if (sv === 1'b1 && rdy === 1'b1) begin
         cmp("stream word", notes.size() > 0 ? notes.pop_front() : 4'hX, sd);
      end
   end
   initial begin
      repeat (12) @(negedge clk);
      rn = 1'b1;
      cmp("reset stage word", 4'h0, st);
      cmp("reset inverted", 4'h1, {3'h0, inv});
      for (i = 0; i < 4; i++) step(!i[1], i[0]);
      $display("test modes done");
      slow = 1'b1;
      for (i = 0; i < 40; i++) step(1'($random(seed)), 1'($random(seed)));
      $display("test random done");
      stall = 1'b1;
      for (i = 0; i < 32; i++) step(1'($random(seed)), 1'b1);
      cmp("full stream valid", 4'h1, {3'h0, sv});
      stall = 1'b0;
      drain();
      $display("test fill done");
      @(negedge clk);
      cn = 1'b0;
      fc = 1'b1;
      #1;
      cmp("clear stage word", 4'h0, st);
      cmp("clear inverted", 4'h1, {3'h0, inv});
      @(negedge clk);
      fc = 1'b0;
      repeat (2) @(negedge clk);
      cn = 1'b1;
      ex = 4'h0;
      step(1'b0, 1'b0);
      drain();
      $display("test clear done");
      test_done();
   end
endmodule
`default_nettype wire
